// ### design/rdtm_top.sv
// Digital core of the two-channel remote diode temperature monitor
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
// What this block does
// R01 - Convert two diodes repeatedly into 8-bit readings
// R02 - Sleep input inactive stops conversion until wake
// R03 - Compare reading with three limits, set status
// R04 - Limit status bits stay set until cleared
// R05 - High or low status sets alert event
// R06 - Overtemp status sets overtemp event flag
// R07 - Shutdown asserts when overtemp status and enabled
// R08 - Combined plus separate per-channel shutdown outputs
// R09 - Alert asserts when enabled and high/low set
// R10 - SYSTEM_MANAGEMENT_REQUEST active when flag and enable set
// R11 - IRQ active when flag and enable set
// R12 - Two banks share 16 bytes, bank 0
// R13 - Values are two's complement, one degree LSB
// R14 - Standby bit halts conversions, registers stay accessible
// R15 - Diode fault check starts every conversion
// R16 - Open diode reads 127, sets open, alerts
// R17 - Shorted diode reads zero, no low status
// R18 - Reading register shows latest value per channel
// R19 - Event flags reset zero, fixed bit layout
// R20 - Write one clears, write zero keeps
// R21 - Limits default 127, 127 and -55
// R22 - Reading is zero until diode converts
// R23 - Host reads flags, channel, then clears
// R24 - Channel limit status bits cleared by one
// R25 - Bank code 0 is diode A, 1 B
// R26 - Config bit1 external reference, bit0 standby
// R27 - Compare once per conversion with own limits
// R28 - Channels alternate, results land in own bank
module rdtm_top (
   // Clock and reset
   input  wire logic                       I_CORE_CLK,
   input  wire logic                       I_SRST,
   // Register port
   input  wire logic [3:0]                 I_ADDR,
   input  wire logic [7:0]                 I_WDATA,
   input  wire logic                       I_WR,
   input  wire logic                       I_RD,
   output logic      [7:0]                 O_RDATA,
   // Converter handshake
   output logic                            O_CONV_START,
   output logic                            O_CONV_CHAN,
   output logic                            O_EXT_REF,
   input  wire rdtm_pkg::rdtm_conv_result_t I_CONV_RESULT,
   // Sleep-state pin, high when active
   input  wire logic                       I_SLEEP_STATE,
   // Alarm outputs
   output logic                            O_ALERT_N,
   output logic                            O_SHUTDOWN_N,
   output logic                            O_SHUTDOWN_A_N,
   output logic                            O_SHUTDOWN_B_N,
   output logic                            O_SMI_REQ_N,
   output logic                            O_IRQ_REQ
);

   // Sleep pin synchroniser and filtered level
   logic                  sleep_s1_reg;
   logic                  sleep_s2_reg;
   logic                  sleep_s3_reg;
   logic                  sleep_act_reg;
   // Common registers
   logic [3:0]            smi_en_reg;
   logic [3:0]            irq_en_reg;
   logic [7:0]            cfg_reg;
   logic [3:0]            bank_reg;
   logic [3:0]            flags_reg;
   // Per-channel registers
   logic [7:0]            chan_cs_reg   [2];
   logic [7:0]            reading_reg   [2];
   logic [7:0]            lim_high_reg  [2];
   logic [7:0]            lim_low_reg   [2];
   logic [7:0]            lim_shut_reg  [2];
   // Sequencer
   rdtm_pkg::rdtm_state_t state_reg;
   logic [8:0]            wake_cnt_reg;
   logic                  woke_reg;
   logic                  chan_reg;
   // Decoded helpers
   logic                  bank_ok;
   logic                  bank_idx;
   logic                  run_ok;
   logic                  done_ok;
   logic [7:0]            conv_value;
   logic                  hit_over;
   logic                  hit_high;
   logic                  hit_low;
   logic                  next_chan;

   // Bank decode; reserved codes reach no channel
   assign bank_ok  = (bank_reg == rdtm_pkg::BANK_REMOTE_A) ||
                     (bank_reg == rdtm_pkg::BANK_REMOTE_B); // R25
   assign bank_idx = (bank_reg == rdtm_pkg::BANK_REMOTE_B); // R12

   // Conversion allowed only out of standby and awake
   assign run_ok = !cfg_reg[rdtm_pkg::CFG_STANDBY] && sleep_act_reg; // R02 R14

   // Result accepted only for the channel asked for
   assign done_ok = (state_reg == rdtm_pkg::ST_WAIT) && I_CONV_RESULT.valid &&
                    (I_CONV_RESULT.chan == chan_reg) && run_ok;

   // Fault handling decides the stored value
   always_comb begin
      if (I_CONV_RESULT.fault_open) begin
         conv_value = rdtm_pkg::READ_OPEN_DIODE; // R16
      end else if (I_CONV_RESULT.fault_short) begin
         conv_value = rdtm_pkg::READ_SHORT_DIODE; // R17
      end else begin
         conv_value = I_CONV_RESULT.data;
      end
   end

   // Signed comparison against the limits of the channel just converted
   always_comb begin
      hit_over = I_CONV_RESULT.fault_open ||
                 ($signed(conv_value) > $signed(lim_shut_reg[chan_reg])); // R03 R13 R27
      hit_high = I_CONV_RESULT.fault_open ||
                 ($signed(conv_value) > $signed(lim_high_reg[chan_reg])); // R03 R16
      hit_low  = !I_CONV_RESULT.fault_short &&
                 ($signed(conv_value) < $signed(lim_low_reg[chan_reg])); // R03 R17
   end

   // Next channel alternates, skipping a disabled one
   always_comb begin
      next_chan = !chan_reg; // R28
      if (!chan_cs_reg[!chan_reg][rdtm_pkg::CS_ENABLE]) begin
         next_chan = chan_reg;
      end
   end

   // Three-stage sync; the filtered level moves once stages two and three agree
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         sleep_s1_reg  <= 1'b0;
         sleep_s2_reg  <= 1'b0;
         sleep_s3_reg  <= 1'b0;
         sleep_act_reg <= 1'b0;
      end else begin
         sleep_s1_reg <= I_SLEEP_STATE;
         sleep_s2_reg <= sleep_s1_reg;
         sleep_s3_reg <= sleep_s2_reg;
         if (sleep_s2_reg == sleep_s3_reg) begin
            sleep_act_reg <= sleep_s3_reg;
         end
      end
   end

   // Common control registers, written in any bank
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         smi_en_reg <= 4'h0;
         irq_en_reg <= 4'h0;
         cfg_reg    <= rdtm_pkg::RST_MONITOR_CFG; // R26
         bank_reg   <= rdtm_pkg::BANK_REMOTE_A; // R12
      end else if (I_WR) begin
         unique case (I_ADDR)
            rdtm_pkg::OFF_SMI_ENABLES: begin
               smi_en_reg <= I_WDATA[3:0];
            end
            rdtm_pkg::OFF_IRQ_ENABLES: begin
               irq_en_reg <= I_WDATA[3:0];
            end
            rdtm_pkg::OFF_MONITOR_CFG: begin
               cfg_reg <= {6'h00, I_WDATA[1:0]}; // R26
            end
            rdtm_pkg::OFF_BANK_SELECT: begin
               bank_reg <= I_WDATA[3:0]; // R25
            end
            default: begin
               // Other offsets hold nothing common
            end
         endcase
      end
   end

   // Limits: software writes to the selected bank only
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         for (int c = 0; c < 2; c++) begin
            lim_high_reg[c] <= rdtm_pkg::RST_LIMIT_HIGH; // R21
            lim_low_reg[c]  <= rdtm_pkg::RST_LIMIT_LOW; // R21
            lim_shut_reg[c] <= rdtm_pkg::RST_LIMIT_SHUT; // R21
         end
      end else if (I_WR && bank_ok) begin
         if (I_ADDR == rdtm_pkg::OFF_CHAN_HIGH) begin
            lim_high_reg[bank_idx] <= I_WDATA;
         end
         if (I_ADDR == rdtm_pkg::OFF_CHAN_LOW) begin
            lim_low_reg[bank_idx] <= I_WDATA;
         end
         if (I_ADDR == rdtm_pkg::OFF_CHAN_SHUT) begin
            lim_shut_reg[bank_idx] <= I_WDATA;
         end
      end
   end

   // Readings: only the channel just converted is updated
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         for (int c = 0; c < 2; c++) begin
            reading_reg[c] <= rdtm_pkg::RST_READING; // R22
         end
      end else if (done_ok) begin
         reading_reg[chan_reg] <= conv_value; // R01 R18 R28
      end
   end

   // Channel configuration and sticky status; a hit beats a same-cycle clear
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         for (int c = 0; c < 2; c++) begin
            chan_cs_reg[c] <= rdtm_pkg::RST_CHAN_CFG_ST;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (I_WR && bank_ok && bank_idx == c[0] && I_ADDR == rdtm_pkg::OFF_CHAN_CFG_ST) begin
               chan_cs_reg[c][rdtm_pkg::CS_ENABLE]   <= I_WDATA[rdtm_pkg::CS_ENABLE];
               chan_cs_reg[c][rdtm_pkg::CS_ALERT_EN] <= I_WDATA[rdtm_pkg::CS_ALERT_EN];
               chan_cs_reg[c][rdtm_pkg::CS_SHUT_EN]  <= I_WDATA[rdtm_pkg::CS_SHUT_EN];
               // Write one clears, write zero keeps
               chan_cs_reg[c][3:1] <= chan_cs_reg[c][3:1] & ~I_WDATA[3:1]; // R20 R24
            end
            if (done_ok && chan_reg == c[0]) begin
               // Hit bits sticky set, never cleared by a later good reading
               if (hit_over) begin
                  chan_cs_reg[c][rdtm_pkg::CS_OVER_HIT] <= 1'b1; // R03 R04
               end
               if (hit_high) begin
                  chan_cs_reg[c][rdtm_pkg::CS_HIGH_HIT] <= 1'b1; // R03 R04
               end
               if (hit_low) begin
                  chan_cs_reg[c][rdtm_pkg::CS_LOW_HIT] <= 1'b1; // R03 R04
               end
               chan_cs_reg[c][rdtm_pkg::CS_OPEN] <= I_CONV_RESULT.fault_open; // R16
            end
         end
      end
   end

   // Event flags mirror the channel status; they fall when software clears it
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         flags_reg <= 4'h0; // R19
      end else begin
         flags_reg[rdtm_pkg::EV_ALERT_A] <= chan_cs_reg[0][rdtm_pkg::CS_HIGH_HIT] |
                                            chan_cs_reg[0][rdtm_pkg::CS_LOW_HIT]; // R05
         flags_reg[rdtm_pkg::EV_OVER_A]  <= chan_cs_reg[0][rdtm_pkg::CS_OVER_HIT]; // R06
         flags_reg[rdtm_pkg::EV_ALERT_B] <= chan_cs_reg[1][rdtm_pkg::CS_HIGH_HIT] |
                                            chan_cs_reg[1][rdtm_pkg::CS_LOW_HIT]; // R05
         flags_reg[rdtm_pkg::EV_OVER_B]  <= chan_cs_reg[1][rdtm_pkg::CS_OVER_HIT]; // R06
      end
   end

   // Sequencer: wake, start (fault check then convert), wait for result
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         state_reg    <= rdtm_pkg::ST_IDLE;
         wake_cnt_reg <= 9'h000;
         woke_reg     <= 1'b0;
         chan_reg     <= 1'b0;
         O_CONV_START <= 1'b0;
      end else begin
         O_CONV_START <= 1'b0;
         // Sleeping loses the wake-up; standby alone does not
         if (!sleep_act_reg) begin
            woke_reg <= 1'b0; // R02
         end
         unique case (state_reg)
            rdtm_pkg::ST_IDLE: begin
               if (run_ok && !woke_reg) begin
                  wake_cnt_reg <= 9'h000;
                  state_reg    <= rdtm_pkg::ST_WAKE;
               end else if (run_ok) begin
                  state_reg <= rdtm_pkg::ST_START;
               end
            end
            rdtm_pkg::ST_WAKE: begin
               if (!run_ok) begin
                  state_reg <= rdtm_pkg::ST_IDLE;
               end else if (wake_cnt_reg == rdtm_pkg::WAKE_LAST) begin
                  woke_reg  <= 1'b1; // R02
                  state_reg <= rdtm_pkg::ST_START;
               end else begin
                  wake_cnt_reg <= wake_cnt_reg + 9'h001;
               end
            end
            rdtm_pkg::ST_START: begin
               if (!run_ok) begin
                  state_reg <= rdtm_pkg::ST_IDLE;
               end else if (chan_cs_reg[chan_reg][rdtm_pkg::CS_ENABLE]) begin
                  // Each start runs the diode fault check first
                  O_CONV_START <= 1'b1; // R15 R01
                  state_reg    <= rdtm_pkg::ST_WAIT;
               end else begin
                  chan_reg <= !chan_reg; // R28
               end
            end
            rdtm_pkg::ST_WAIT: begin
               if (!run_ok) begin
                  // A result arriving later is dropped
                  state_reg <= rdtm_pkg::ST_IDLE; // R02 R14
               end else if (done_ok) begin
                  chan_reg  <= next_chan; // R28
                  state_reg <= rdtm_pkg::ST_START;
               end
            end
         endcase
      end
   end

   // Register read data, valid only in the cycle after the strobe
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_RDATA <= 8'h00;
      end else if (I_RD) begin
         O_RDATA <= 8'h00;
         unique case (I_ADDR)
            rdtm_pkg::OFF_EVENT_FLAGS:  O_RDATA <= {4'h0, flags_reg}; // R19
            rdtm_pkg::OFF_SMI_ENABLES:  O_RDATA <= {4'h0, smi_en_reg};
            rdtm_pkg::OFF_IRQ_ENABLES:  O_RDATA <= {4'h0, irq_en_reg};
            rdtm_pkg::OFF_MONITOR_CFG:  O_RDATA <= cfg_reg;
            rdtm_pkg::OFF_BANK_SELECT:  O_RDATA <= {4'h0, bank_reg};
            rdtm_pkg::OFF_CHAN_CFG_ST:  O_RDATA <= bank_ok ? chan_cs_reg[bank_idx] : 8'h00;
            rdtm_pkg::OFF_CHAN_READING: O_RDATA <= bank_ok ? reading_reg[bank_idx] : 8'h00; // R18
            rdtm_pkg::OFF_CHAN_HIGH:    O_RDATA <= bank_ok ? lim_high_reg[bank_idx] : 8'h00;
            rdtm_pkg::OFF_CHAN_LOW:     O_RDATA <= bank_ok ? lim_low_reg[bank_idx] : 8'h00;
            rdtm_pkg::OFF_CHAN_SHUT:    O_RDATA <= bank_ok ? lim_shut_reg[bank_idx] : 8'h00;
            default:                    O_RDATA <= 8'h00;
         endcase
      end else begin
         O_RDATA <= 8'h00;
      end
   end

   // Alarm and request outputs, all registered from status and flags
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_ALERT_N      <= 1'b1;
         O_SHUTDOWN_N   <= 1'b1;
         O_SHUTDOWN_A_N <= 1'b1;
         O_SHUTDOWN_B_N <= 1'b1;
         O_SMI_REQ_N    <= 1'b1;
         O_IRQ_REQ      <= 1'b0;
         O_CONV_CHAN    <= 1'b0;
         O_EXT_REF      <= 1'b1;
      end else begin
         O_ALERT_N <= !((chan_cs_reg[0][rdtm_pkg::CS_ALERT_EN] &&
                         (chan_cs_reg[0][rdtm_pkg::CS_HIGH_HIT] ||
                          chan_cs_reg[0][rdtm_pkg::CS_LOW_HIT])) ||
                        (chan_cs_reg[1][rdtm_pkg::CS_ALERT_EN] &&
                         (chan_cs_reg[1][rdtm_pkg::CS_HIGH_HIT] ||
                          chan_cs_reg[1][rdtm_pkg::CS_LOW_HIT]))); // R09
         O_SHUTDOWN_A_N <= !(chan_cs_reg[0][rdtm_pkg::CS_SHUT_EN] &&
                             chan_cs_reg[0][rdtm_pkg::CS_OVER_HIT]); // R07 R08
         O_SHUTDOWN_B_N <= !(chan_cs_reg[1][rdtm_pkg::CS_SHUT_EN] &&
                             chan_cs_reg[1][rdtm_pkg::CS_OVER_HIT]); // R07 R08
         O_SHUTDOWN_N   <= !((chan_cs_reg[0][rdtm_pkg::CS_SHUT_EN] &&
                              chan_cs_reg[0][rdtm_pkg::CS_OVER_HIT]) ||
                             (chan_cs_reg[1][rdtm_pkg::CS_SHUT_EN] &&
                              chan_cs_reg[1][rdtm_pkg::CS_OVER_HIT])); // R08
         O_SMI_REQ_N <= !(|(flags_reg & smi_en_reg)); // R10
         O_IRQ_REQ   <= |(flags_reg & irq_en_reg); // R11
         O_CONV_CHAN <= (state_reg == rdtm_pkg::ST_START) ? chan_reg : O_CONV_CHAN;
         O_EXT_REF   <= cfg_reg[rdtm_pkg::CFG_EXT_REF]; // R26
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SRST);

   // Stored reading equals the fault-adjusted result
   AST_READING_STORED: assert property (done_ok |=> // R01
      reading_reg[$past(chan_reg)] == $past(conv_value)) else $error("reading not stored");
   // No start while asleep or in standby
   AST_NO_START_IDLE: assert property (!run_ok |=> !O_CONV_START) // R02
      else $error("conversion started while halted");
   AST_STANDBY_START: assert property (cfg_reg[0] [*2] |-> !O_CONV_START) // R14
      else $error("conversion started in standby");
   // Status bit sticks without a clearing write
   AST_STATUS_STICKY: assert property (chan_cs_reg[0][3] &&
      !(I_WR && I_ADDR == rdtm_pkg::OFF_CHAN_CFG_ST) |=> chan_cs_reg[0][3]) // R04
      else $error("status bit lost");
   // Write one clears when no hit arrives
   AST_W1C_CLEAR: assert property (I_WR && bank_reg == 4'h0 && I_WDATA[2] &&
      I_ADDR == rdtm_pkg::OFF_CHAN_CFG_ST && !done_ok |=> !chan_cs_reg[0][2]) // R20
      else $error("status bit not cleared");
   // Alert flag follows high or low status
   AST_ALERT_FLAG: assert property ((chan_cs_reg[1][2] || chan_cs_reg[1][1]) |=> // R05
      flags_reg[rdtm_pkg::EV_ALERT_B]) else $error("alert flag missing");
   AST_OVER_FLAG: assert property (chan_cs_reg[0][3] |=> flags_reg[1]) // R06
      else $error("overtemp flag missing");
   // Shutdown reaches pins within two cycles of status
   AST_SHUTDOWN: assert property ((chan_cs_reg[1][3] && chan_cs_reg[1][5]) [*2] |->
      !O_SHUTDOWN_B_N && !O_SHUTDOWN_N) else $error("shutdown not asserted"); // R07
   AST_SMI_REQ: assert property (|(flags_reg & smi_en_reg) |=> !O_SMI_REQ_N) // R10
      else $error("smi not requested");
   AST_IRQ_REQ: assert property (!(|(flags_reg & irq_en_reg)) |=> !O_IRQ_REQ) // R11
      else $error("irq without cause");
   // Open diode result is stored as 127 in the converted channel
   AST_OPEN_DIODE: assert property (done_ok && I_CONV_RESULT.fault_open |=> // R16
      reading_reg[$past(chan_reg)] == rdtm_pkg::READ_OPEN_DIODE) else $error("open value");

endmodule // rdtm_top

// ### design/rdtm_pkg.sv
// Package of constants and types for the remote diode temperature monitor
package rdtm_pkg;
   // Register offsets within the 16-byte space
   localparam logic [3:0] OFF_EVENT_FLAGS  = 4'h0;
   localparam logic [3:0] OFF_SMI_ENABLES  = 4'h2;
   localparam logic [3:0] OFF_IRQ_ENABLES  = 4'h4;
   localparam logic [3:0] OFF_MONITOR_CFG  = 4'h8;
   localparam logic [3:0] OFF_BANK_SELECT  = 4'h9;
   localparam logic [3:0] OFF_CHAN_CFG_ST  = 4'ha;
   localparam logic [3:0] OFF_CHAN_READING = 4'hb;
   localparam logic [3:0] OFF_CHAN_HIGH    = 4'hc;
   localparam logic [3:0] OFF_CHAN_LOW     = 4'hd;
   localparam logic [3:0] OFF_CHAN_SHUT    = 4'he;
   // Event flag bit positions per channel (alert, overtemp)
   localparam int EV_ALERT_A = 0;
   localparam int EV_OVER_A  = 1;
   localparam int EV_ALERT_B = 2;
   localparam int EV_OVER_B  = 3;
   // Channel configuration and status bit positions
   localparam int CS_ENABLE   = 0;
   localparam int CS_LOW_HIT  = 1;
   localparam int CS_HIGH_HIT = 2;
   localparam int CS_OVER_HIT = 3;
   localparam int CS_ALERT_EN = 4;
   localparam int CS_SHUT_EN  = 5;
   localparam int CS_OPEN     = 6;
   // Monitor configuration bit positions
   localparam int CFG_STANDBY = 0;
   localparam int CFG_EXT_REF = 1;
   // Reset values
   localparam logic [7:0] RST_MONITOR_CFG = 8'h03;
   localparam logic [7:0] RST_CHAN_CFG_ST = 8'h00;
   localparam logic [7:0] RST_LIMIT_HIGH  = 8'h7f;
   localparam logic [7:0] RST_LIMIT_SHUT  = 8'h7f;
   localparam logic [7:0] RST_LIMIT_LOW   = 8'hc9;
   localparam logic [7:0] RST_READING     = 8'h00;
   // Fixed readings on diode faults
   localparam logic [7:0] READ_OPEN_DIODE  = 8'h7f;
   localparam logic [7:0] READ_SHORT_DIODE = 8'h00;
   // Bank select codes
   localparam logic [3:0] BANK_REMOTE_A = 4'h0;
   localparam logic [3:0] BANK_REMOTE_B = 4'h1;
   // Wake-up sequence length after the sleep-state input turns active
   localparam int WAKE_TIME_NS   = 1000;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int WAKE_CYCLES    = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] WAKE_LAST = 9'(WAKE_CYCLES - 1);
   // Conversion sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_START, ST_WAIT} rdtm_state_t;
   // Result handed back by the converter after fault check and conversion
   typedef struct packed {
      logic       valid;
      logic       chan;
      logic       fault_open;
      logic       fault_short;
      logic [7:0] data;
   } rdtm_conv_result_t;
endpackage

// ### test/rdtm_diode_model.sv
// Behavioural model of the converter and the two remote diodes
`timescale 1ns/1ns
module rdtm_diode_model (
   // Clock
   input  wire logic                        i_clk,
   // Converter requests
   input  wire logic                        i_start,
   input  wire logic                        i_chan,
   // Scenario control
   input  wire logic [7:0]                  i_temp_a,
   input  wire logic [7:0]                  i_temp_b,
   input  wire logic                        i_open_b,
   input  wire logic                        i_short_a,  // Anode of diode A shorted
   // Result back to the core
   output rdtm_pkg::rdtm_conv_result_t      o_result
);
   int   wait_cnt = -1;  // Cycles left, -1 when idle
   logic chan_reg = 1'b0; // Channel under conversion
   int   n_done   = 0;   // Alternates prompt and slow answers
   // Answer each start after 4 or 21 cycles; idle data toggles
   always @(posedge i_clk) begin
      o_result.valid <= 1'b0;
      o_result.data  <= ~o_result.data; // Released bus never holds a value
      if (i_start) begin
         chan_reg <= i_chan;
         wait_cnt <= (n_done % 2) ? 20 : 3;
      end else if (wait_cnt == 0) begin
         // Fault check result rides with every conversion
         o_result.valid       <= 1'b1;
         o_result.chan        <= chan_reg;
         o_result.fault_open  <= chan_reg & i_open_b;
         o_result.fault_short <= !chan_reg & i_short_a;
         o_result.data        <= chan_reg ? i_temp_b : i_temp_a;
         n_done   <= n_done + 1;
         wait_cnt <= -1;
      end else if (wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
   initial o_result = '0;
endmodule // rdtm_diode_model

// ### test/rdtm_top_test.sv
// Self-checking testbench of the remote diode temperature monitor
`timescale 1ns/1ns
module rdtm_top_test;
   logic clk = 0, srst = 1, wr = 0, rd = 0, sleep = 0, open_b = 0, short_a = 0;
   logic [3:0] addr = '0;
   logic [7:0] wdata = '0, rdata, temp_a = 8'h7d, temp_b = 8'he7;
   logic start, chan, ext_ref, alert_n, shut_n, shut_a_n, shut_b_n, smi_n, irq;
   rdtm_pkg::rdtm_conv_result_t res;
   int err_total = 0, n_checks = 0;
   always #2 clk = ~clk;
   rdtm_top DUT (.I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_CONV_START(start), .O_CONV_CHAN(chan),
      .O_EXT_REF(ext_ref), .I_CONV_RESULT(res), .I_SLEEP_STATE(sleep),
      .O_ALERT_N(alert_n), .O_SHUTDOWN_N(shut_n), .O_SHUTDOWN_A_N(shut_a_n),
      .O_SHUTDOWN_B_N(shut_b_n), .O_SMI_REQ_N(smi_n), .O_IRQ_REQ(irq));
   rdtm_diode_model PART (.i_clk(clk), .i_start(start), .i_chan(chan), .i_temp_a(temp_a),
      .i_temp_b(temp_b), .i_open_b(open_b), .i_short_a(short_a), .o_result(res));
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One-cycle register write
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read a register and compare; data stands the cycle after the strobe
   task automatic chk_reg(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 n_checks++;
      if (rdata !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, rdata);
      end
   endtask
   // Compare a pin level once alarm outputs have settled
   task automatic chk_pin(input string nm, input logic v, input logic e);
      n_checks++;
      if (v !== e) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", nm, e, v);
      end
   endtask
   // Wait for n converter answers, bounded
   task automatic wait_res(input int n);
      int k;
      k = 0;
      while (n > 0) begin
         @(posedge clk);
         if (res.valid === 1'b1) n--;
         if (++k > 3000) begin
            err_total++;
            $display("wrong value timeout expected answer seen none");
            final_report();
         end
      end
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      chk_reg("cfg", 4'h8, 8'h03);
      chk_reg("flags", 4'h0, 8'h00);
      chk_reg("high", 4'hc, 8'h7f);
      chk_reg("low", 4'hd, 8'hc9);
      chk_reg("shut", 4'he, 8'h7f);
      chk_reg("reading", 4'hb, 8'h00);
      chk_reg("hole", 4'hf, 8'h00);
      chk_pin("ext_ref", ext_ref, 1'b1);
      $display("reset values done");
      // Enable both channels; A crosses high, B crosses low
      sleep <= 1'b1;
      wr_reg(4'ha, 8'h31);
      wr_reg(4'hc, 8'h19);
      wr_reg(4'h9, 8'h01);
      wr_reg(4'ha, 8'h31);
      wr_reg(4'hd, 8'h00);
      chk_reg("standby", 4'hb, 8'h00);
      wr_reg(4'h8, 8'h00);
      wait_res(4);
      chk_reg("read b", 4'hb, 8'he7);
      chk_reg("stat b", 4'ha, 8'h33);
      wr_reg(4'h9, 8'h00);
      chk_reg("read a", 4'hb, 8'h7d);
      chk_reg("stat a", 4'ha, 8'h35);
      chk_reg("flags", 4'h0, 8'h05);
      chk_pin("alert", alert_n, 1'b0);
      chk_pin("shut", shut_n, 1'b1);
      $display("limit test done");
      // Back inside limits; status must stay until cleared
      temp_a <= 8'h19;
      temp_b <= 8'h19;
      wait_res(4);
      chk_reg("sticky", 4'ha, 8'h35);
      wr_reg(4'ha, 8'h31);
      chk_reg("zero wr", 4'ha, 8'h35);
      wr_reg(4'ha, 8'h35);
      chk_reg("cleared", 4'ha, 8'h31);
      chk_reg("flags", 4'h0, 8'h04);
      wr_reg(4'h2, 8'h04);
      wr_reg(4'h4, 8'h01);
      repeat (4) @(posedge clk);
      #1;
      chk_pin("smi", smi_n, 1'b0);
      chk_pin("irq", irq, 1'b0);
      $display("clear test done");
      // Open diode on channel B
      open_b <= 1'b1;
      wait_res(4);
      wr_reg(4'h9, 8'h01);
      chk_reg("open rd", 4'hb, 8'h7f);
      chk_reg("open st", 4'ha, 8'h7f);
      chk_reg("flags", 4'h0, 8'h0c);
      wr_reg(4'h4, 8'h08);
      repeat (4) @(posedge clk);
      #1;
      chk_pin("irq", irq, 1'b1);
      chk_pin("shut", shut_n, 1'b0);
      chk_pin("shut b", shut_b_n, 1'b0);
      chk_pin("shut a", shut_a_n, 1'b1);
      wr_reg(4'h9, 8'h02);
      chk_reg("bank2", 4'hc, 8'h00);
      $display("open diode test done");
      // Shorted diode A reads zero and raises no low status
      wr_reg(4'h9, 8'h00);
      wr_reg(4'hd, 8'h19);
      short_a <= 1'b1;
      wait_res(4);
      chk_reg("short rd", 4'hb, 8'h00);
      chk_reg("short st", 4'ha, 8'h31);
      // Sleep input low: results frozen until wake-up completes
      sleep <= 1'b0;
      repeat (10) @(posedge clk);
      short_a <= 1'b0;
      temp_a  <= 8'h05;
      repeat (100) @(posedge clk);
      chk_reg("asleep", 4'hb, 8'h00);
      sleep <= 1'b1;
      wait_res(4);
      chk_reg("awake", 4'hb, 8'h05);
      $display("short and sleep test done");
      final_report();
   end
endmodule // rdtm_top_test
